// file: verilog/p0cfg_port.sv
// Purpose: Port 0 latch, pin readback and pin configuration registers.
// Assumes: Bus inputs synchronous to clk; one access per cycle.
// Notes: A bit write replaces one bit of the addressed register and keeps the others.
`timescale 1ns/10ps
module p0cfg_port #(
    parameter int PIN_COUNT = 8,
    parameter int INDEX_BITS = 3
) (
    // Clock and control.
    input wire logic clk,
    input wire logic srst,
    input wire logic clk_en,
    // Register bus.
    input wire p0cfg_pkg::p0cfg_req_s req,
    output logic [7:0] rdata,
    output logic rvalid,
    // Pins and crossbar.
    input wire logic [7:0] pin_level,
    output p0cfg_pkg::p0cfg_pad_s pad
);
    import p0cfg_pkg::*;


    // Every register is one byte wide, so only eight pins and a three-bit bit index can be served.
    if (PIN_COUNT != PINS) begin : g_bad_pins
        $error("p0cfg_port serves exactly eight pins");
    end
    if (INDEX_BITS != BIT_IDX_W) begin : g_bad_index
        $error("p0cfg_port needs a three-bit bit index");
    end

    // Output latch and the three configuration registers, one bit per pin.
    logic [7:0] port_zero_pin_data;
    logic [7:0] driver_type_select;
    logic [7:0] pin_skip_bits;
    logic [7:0] analog_digital_select;

    // Merges a bus write into a register's present value.
    function automatic logic [7:0] merge(input logic [7:0] cur, input p0cfg_req_s r);
        logic [7:0] res;
        res = cur;
        if (r.bit_op) begin
            res[r.bit_idx] = r.wdata[0];
        end else begin
            res = r.wdata;
        end
        return res;
    endfunction : merge

    // Tells whether a bus address selects the given register.
    function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
        return addr == target;
    endfunction : addr_is

    // Register selects shared by the write path and the read path.
    wire hit_data = addr_is(req.addr, ADDR_DATA);
    wire hit_out = addr_is(req.addr, ADDR_OUT_MODE);
    wire hit_skip = addr_is(req.addr, ADDR_SKIP);
    wire hit_in = addr_is(req.addr, ADDR_IN_MODE);

    // Plain reads see the pins; read-modify-write reads see the latch so other pins are not disturbed.
    wire [7:0] data_view = req.rmw ? port_zero_pin_data : pin_level;
    wire [7:0] sel_byte = hit_data ? data_view :
                          hit_out ? driver_type_select :
                          hit_skip ? pin_skip_bits :
                          hit_in ? analog_digital_select : 8'h00;
    wire [7:0] next_rdata = req.bit_op ? {7'h00, sel_byte[req.bit_idx]} : sel_byte;

    always_ff @(posedge clk) begin
        if (srst) begin
            port_zero_pin_data <= RST_DATA;
            driver_type_select <= RST_OUT_MODE;
            pin_skip_bits <= RST_SKIP;
            analog_digital_select <= RST_IN_MODE;
        end else if (clk_en && req.wr) begin
            if (hit_data) port_zero_pin_data <= merge(port_zero_pin_data, req);
            if (hit_out) driver_type_select <= merge(driver_type_select, req);
            if (hit_skip) pin_skip_bits <= merge(pin_skip_bits, req);
            if (hit_in) analog_digital_select <= merge(analog_digital_select, req);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else if (clk_en) begin
            rvalid <= req.rd;
            if (req.rd) rdata <= next_rdata;
        end
    end

    // Per-pin gating of the weak pull-up and the digital receiver by the input-mode bit.
    // The output driver is deliberately not gated, so an analog pin can still be driven.
    wire [7:0] pullup_vec;
    wire [7:0] receiver_vec;
    for (genvar n = 0; n < PIN_COUNT; n++) begin : g_pin
        assign pullup_vec[n] = analog_digital_select[n];
        assign receiver_vec[n] = analog_digital_select[n];
    end

    // All pad and crossbar controls leave as one carrier, each field straight from its register.
    assign pad = '{
        out_level: port_zero_pin_data,
        push_pull: driver_type_select,
        pullup_en: pullup_vec,
        rx_en: receiver_vec,
        skip: pin_skip_bits
    };

    // All checks below run on the system clock; all but reset_values_a stand aside during reset.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // A whole-byte write to one register, taken on this edge.
    sequence byte_wr(logic [7:0] a);
        clk_en && req.wr && !req.bit_op && addr_is(req.addr, a);
    endsequence

    // A single-bit write to one register, taken on this edge.
    sequence bit_wr(logic [7:0] a);
        clk_en && req.wr && req.bit_op && addr_is(req.addr, a);
    endsequence

    // A whole-byte read of the data register, from the pins or from the latch.
    sequence data_rd(logic m);
        clk_en && req.rd && !req.bit_op && hit_data && req.rmw == m;
    endsequence

    // An edge on which the clock enable holds every register still.
    sequence frozen_cycle;
        !clk_en;
    endsequence

    latch_holds_write_a: assert property (byte_wr(ADDR_DATA) |=> pad.out_level == $past(req.wdata))
        else $error("latch lost write");

    skip_write_a: assert property (byte_wr(ADDR_SKIP) |=> pad.skip == $past(req.wdata))
        else $error("skip not written");

    skip_bit_write_a: assert property (bit_wr(ADDR_SKIP) |=>
        pad.skip[$past(req.bit_idx)] == $past(req.wdata[0]))
        else $error("skip bit not written");

    analog_off_a: assert property (byte_wr(ADDR_IN_MODE) |=>
        pad.rx_en == $past(req.wdata) && pad.pullup_en == $past(req.wdata))
        else $error("analog mode gating wrong");

    // A reset changes every register at once, so the edge just after it is left out.
    driver_kept_a: assert property (!$past(srst) && $changed(analog_digital_select) |->
        $stable(pad.out_level) && $stable(pad.push_pull))
        else $error("analog mode moved driver");

    mode_write_a: assert property (byte_wr(ADDR_OUT_MODE) |=> pad.push_pull == $past(req.wdata))
        else $error("mode not written");

    mode_bit_write_a: assert property (bit_wr(ADDR_OUT_MODE) |=>
        pad.push_pull[$past(req.bit_idx)] == $past(req.wdata[0]))
        else $error("mode bit not written");

    pin_read_a: assert property (data_rd(1'b0) |=> rvalid && rdata == $past(pin_level))
        else $error("pin read wrong");

    rmw_read_a: assert property (data_rd(1'b1) |=> rvalid && rdata == $past(port_zero_pin_data))
        else $error("rmw read wrong");

    bit_write_a: assert property (bit_wr(ADDR_DATA) |=>
        port_zero_pin_data[$past(req.bit_idx)] == $past(req.wdata[0]))
        else $error("bit write wrong");

    bit_read_a: assert property (clk_en && req.rd && req.bit_op |=> rdata[7:1] == 7'h00)
        else $error("bit read upper bits set");

    read_pulse_a: assert property (clk_en |=> rvalid == $past(req.rd))
        else $error("read valid pulse wrong");

    state_frozen_a: assert property (frozen_cycle |=>
        $stable(port_zero_pin_data) && $stable(driver_type_select) && $stable(pin_skip_bits) &&
        $stable(analog_digital_select) && $stable(rvalid) && $stable(rdata))
        else $error("state moved while disabled");

    reset_values_a: assert property (disable iff (1'b0) srst |=>
        port_zero_pin_data == RST_DATA && driver_type_select == RST_OUT_MODE &&
        pin_skip_bits == RST_SKIP && analog_digital_select == RST_IN_MODE && !rvalid)
        else $error("reset values wrong");
endmodule : p0cfg_port

// file: inc/p0cfg_pkg.sv
// Purpose: Constants and carriers for the port 0 pin configuration block.
// Assumes: An 8-bit special-function-register bus with byte and bit access.
// Notes: Offsets are the register addresses on that bus.
package p0cfg_pkg;
    localparam int PINS = 8;
    localparam logic [7:0] ADDR_DATA = 8'h80;
    localparam logic [7:0] ADDR_OUT_MODE = 8'hA4;
    localparam logic [7:0] ADDR_SKIP = 8'hD4;
    localparam logic [7:0] ADDR_IN_MODE = 8'hF1;
    localparam logic [7:0] RST_DATA = 8'hFF;
    localparam logic [7:0] RST_OUT_MODE = 8'h00;
    localparam logic [7:0] RST_SKIP = 8'h00;
    localparam logic [7:0] RST_IN_MODE = 8'hFF;
    localparam int BIT_IDX_W = 3;

    // One access on the register bus.
    typedef struct packed {
        logic wr;
        logic rd;
        logic rmw;
        logic bit_op;
        logic [BIT_IDX_W-1:0] bit_idx;
        logic [7:0] addr;
        logic [7:0] wdata;
    } p0cfg_req_s;

    // Per-pin controls toward the pad cells and crossbar.
    typedef struct packed {
        logic [7:0] out_level;
        logic [7:0] push_pull;
        logic [7:0] pullup_en;
        logic [7:0] rx_en;
        logic [7:0] skip;
    } p0cfg_pad_s;
endpackage : p0cfg_pkg

// file: tb/p0cfg_port_test.sv
// Purpose: Self-checking bench for the port 0 pin configuration block.
// Assumes: Inputs change at the falling edge; reset held two cycles at the start and one cycle mid-test.
// Notes: Expected values come from the register table and the pin rules.
`timescale 1ns/10ps
module p0cfg_port_test;
    import p0cfg_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic clk_en = 1'b1;
    p0cfg_req_s req = '0;
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] pin_level = 8'hA3;
    p0cfg_pad_s pad;
    int n_mismatch = 0;
    int comparisons = 0;
    always #50 clk = ~clk;
    p0cfg_port dut (.clk(clk), .srst(srst), .clk_en(clk_en), .req(req), .rdata(rdata), .rvalid(rvalid),
        .pin_level(pin_level), .pad(pad));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One bus access: raised at a falling edge and taken at the rising edge that follows.
    task automatic acc(input logic w, input logic r, input logic m, input logic b, input logic [2:0] i,
        input logic [7:0] a, input logic [7:0] d);
        req = '{w, r, m, b, i, a, d};
        @(negedge clk);
    endtask : acc
    // Lowers the request for one cycle, so a strobe is never lowered and raised in one time step.
    task automatic idle;
        req = '0;
        @(negedge clk);
    endtask : idle
    task automatic wr(input logic [7:0] a, input logic b, input logic [2:0] i, input logic [7:0] d);
        acc(1'b1, 1'b0, 1'b0, b, i, a, d);
        idle();
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic m, input logic b, input logic [2:0] i,
        input logic [7:0] exp);
        acc(1'b0, 1'b1, m, b, i, a, 8'h00);
        chk({7'h00, rvalid}, 8'h01);
        chk(rdata, exp);
        idle();
        chk({7'h00, rvalid}, 8'h00);
        chk(rdata, exp);
    endtask : rd
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    initial begin
        #100000;
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (2) @(negedge clk);
        srst = 1'b0;
        chk(pad.out_level, RST_DATA);
        chk(pad.push_pull, RST_OUT_MODE);
        rd(ADDR_OUT_MODE, 1'b0, 1'b0, 3'h0, 8'h00);
        rd(ADDR_SKIP, 1'b0, 1'b0, 3'h0, 8'h00);
        rd(ADDR_IN_MODE, 1'b0, 1'b0, 3'h0, 8'hFF);
        wr(ADDR_DATA, 1'b0, 3'h0, 8'h55);
        chk(pad.out_level, 8'h55);
        rd(ADDR_DATA, 1'b0, 1'b0, 3'h0, 8'hA3);
        rd(ADDR_DATA, 1'b1, 1'b0, 3'h0, 8'h55);
        // Pins 0 to 3 serve plain I/O here, so software skips them.
        wr(ADDR_SKIP, 1'b0, 3'h0, 8'h0F);
        chk(pad.skip, 8'h0F);
        wr(ADDR_IN_MODE, 1'b0, 3'h0, 8'h5A);
        chk(pad.rx_en, 8'h5A);
        chk(pad.pullup_en, 8'h5A);
        wr(ADDR_OUT_MODE, 1'b0, 3'h0, 8'hC3);
        chk(pad.push_pull, 8'hC3);
        chk(pad.out_level, 8'h55);
        wr(ADDR_SKIP, 1'b1, 3'h7, 8'h01);
        chk(pad.skip, 8'h8F);
        rd(ADDR_IN_MODE, 1'b0, 1'b1, 3'h0, 8'h00);
        rd(ADDR_IN_MODE, 1'b0, 1'b1, 3'h1, 8'h01);
        wr(ADDR_DATA, 1'b1, 3'h0, 8'h00);
        chk(pad.out_level, 8'h54);
        rd(ADDR_DATA, 1'b1, 1'b1, 3'h2, 8'h01);
        pin_level = 8'h3C;
        rd(ADDR_DATA, 1'b0, 1'b0, 3'h0, 8'h3C);
        wr(8'h81, 1'b0, 3'h0, 8'hFF);
        rd(8'h81, 1'b0, 1'b0, 3'h0, 8'h00);
        chk(pad.skip, 8'h8F);
        clk_en = 1'b0;
        wr(ADDR_DATA, 1'b0, 3'h0, 8'hAA);
        clk_en = 1'b1;
        chk(pad.out_level, 8'h54);
        srst = 1'b1;
        @(negedge clk);
        srst = 1'b0;
        chk(pad.out_level, RST_DATA);
        chk(pad.skip, RST_SKIP);
        chk(pad.rx_en, RST_IN_MODE);
        chk(pad.push_pull, RST_OUT_MODE);
        summarize();
    end
endmodule : p0cfg_port_test
